// ### include/tscw_pkg.sv
// Package for the TDM switch connection-word decoder.
// Assumes a single clock domain and a plain register port.
package tscw_pkg;
    // Connection word field positions
    localparam int CW_WIDTH = 16;
    localparam int LOOPBACK_BIT = 15;
    localparam int CONSTDELAY_BIT = 14;
    localparam int MESSAGE_BIT = 13;
    localparam int CTRLOUT_BIT = 12;
    localparam int OUTEN_BIT = 11;
    localparam int STREAM_HI = 10;
    localparam int STREAM_LO = 7;
    localparam int CHAN_HI = 6;
    localparam int CHAN_LO = 0;
    localparam int MSG_HI = 7;
    localparam int STREAM_W = 4;
    localparam int CHAN_W = 7;
    // Data rate codes
    localparam logic [1:0] RATE_LOW = 2'h0;
    localparam logic [1:0] RATE_MID = 2'h1;
    localparam logic [1:0] RATE_HIGH = 2'h2;
    // Register map (word addresses of the plain port)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h01;
    localparam logic [7:0] ADDR_OFFSET = 8'h02;
    localparam logic [7:0] ADDR_CMEM_SEL = 8'h03;
    localparam logic [7:0] ADDR_CMEM_DATA = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    // Reset values
    localparam logic [15:0] CW_RESET = 16'h0000;
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [11:0] DELAY_RESET = 12'h800;
    // Offset register layout: per stream {offset[2:0], half_cycle_enable}
    localparam int OFS_FIELD_W = 4;
    localparam int OFS_HALF_POS = 0;
    localparam int OFS_VAL_POS = 1;
endpackage

// ### include/tscw_slot_if.sv
// Interface carrying one decoded connection word between the decoder and the core.
// Assumes both ends share clk_sys.
`timescale 1ns/10ps
interface tscw_slot_if;
    logic [15:0] word;
    logic [1:0] rate;
    logic messageSel;
    logic constDelay;
    logic outEnable;
    logic ctrlBit;
    logic loopback;
    logic [3:0] srcStream;
    logic [6:0] srcChannel;
    logic [7:0] msgByte;
    modport decoder (input word, input rate, output messageSel, output constDelay, output outEnable,
        output ctrlBit, output loopback, output srcStream, output srcChannel, output msgByte);
    modport user (output word, output rate, input messageSel, input constDelay, input outEnable,
        input ctrlBit, input loopback, input srcStream, input srcChannel, input msgByte);
endinterface

// ### verilog/tscw_word_decode.sv
// Combinational field decoder for one connection word.
// Assumes the word and rate come from the switch core.
`timescale 1ns/10ps
module tscw_word_decode
    import tscw_pkg::*;
(
    tscw_slot_if.decoder slot
);
    function automatic logic [6:0] maskChannel(input logic [6:0] chan, input logic [1:0] rate);
        logic [6:0] m;
        m = 7'h7f;
        if (rate == RATE_LOW) begin
            m = 7'h1f;
        end else if (rate == RATE_MID) begin
            m = 7'h3f;
        end
        return chan & m;
    endfunction

    always_comb begin
        slot.loopback = slot.word[LOOPBACK_BIT];
        slot.constDelay = slot.word[CONSTDELAY_BIT];
        slot.messageSel = slot.word[MESSAGE_BIT];
        slot.ctrlBit = slot.word[CTRLOUT_BIT];
        slot.outEnable = slot.word[OUTEN_BIT];
        slot.srcStream = slot.word[STREAM_HI:STREAM_LO];
        slot.srcChannel = maskChannel(slot.word[CHAN_HI:CHAN_LO], slot.rate);
        slot.msgByte = slot.word[MSG_HI:0];
    end
endmodule

// ### verilog/tscw_switch.sv
// Connection-word core of a time-slot switch: connection memory, per-slot decode,
// serial output byte selection, control-output bit stream and per-stream input offset.
// Assumes serial framing (stream/channel counters) arrives as synchronous inputs.
//
// Contract
// - A measured delay of half flag one and low count zero yields all-zero offset bits.
// - Offset field equals the three low measured delay bits and half-cycle enable is the inverted half flag.
// - With loopback set, input stream n channel m takes the data sent on output stream n channel m.
// - Bit 14 selects constant (one) or variable (zero) throughput delay per channel.
// - With the message bit set the word's own contents are sent instead of switched data.
// - In message mode only bits 7 to 0 are driven onto the output channel.
// - With the message bit clear, stream and channel fields form the data-memory read address.
// - Bit 12 is driven on the control output one channel time ahead of its channel.
// - Control-output bits go out in stream order starting at stream 0 each channel period.
// - Bit 11 enables the serial output driver for the channel; zero floats it.
// - Bits 10 to 7 are the source stream number.
// - Bits 6 to 0 are the source channel number.
// - The source channel uses 5, 6 or 7 bits at the low, middle and high rate.
// - The half flag is one when the evaluation edge fell in the clock-high phase.
`timescale 1ns/10ps
module tscw_switch
    import tscw_pkg::*;
#(
    parameter int STREAMS = 16,
    parameter int CHANNELS = 128
)(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData_ff,
    // Frame timing from the serial front end
    input wire logic [3:0] slotStream,
    input wire logic [6:0] slotChannel,
    input wire logic slotStrobe,
    input wire logic [3:0] ctrlStream,
    input wire logic [6:0] ctrlChannel,
    input wire logic ctrlStrobe,
    // Measured frame delay from the evaluation logic, and the data memory read byte
    input wire logic [11:0] measuredDelay,
    input wire logic evaluationDone,
    input wire logic [7:0] dataMemRdByte,
    // Data memory and output
    output logic [10:0] dataMemAddr_ff,
    output logic [7:0] serialOutByte_ff,
    output logic serialOutEnable_ff,
    output logic constDelay_ff,
    output logic loopbackWrite_ff,
    output logic [10:0] loopbackAddr_ff,
    output logic controlSerialOut_ff,
    output logic [3:0] streamOffset_ff,
    output logic halfCycleEnable_ff
);
    localparam int DEPTH = STREAMS * CHANNELS;
    localparam int AW = $clog2(DEPTH);

    // Address packing and field widths below are fixed to this geometry
    if (STREAMS != 16 || CHANNELS != 128) begin : g_param_check
        $error("tscw_switch supports 16 streams of 128 channels only");
    end

    logic [15:0] connMem [DEPTH];
    logic [1:0] rate_ff;
    logic [10:0] cmemSel_ff;
    logic [11:0] delay_ff;
    logic delayValid_ff;
    logic [OFS_FIELD_W*16-1:0] offsets_ff;
    logic [3:0] offsetSel_ff;
    logic [15:0] slotWord;
    logic [15:0] ctrlWord;
    logic [15:0] cmemRead;

    tscw_slot_if slot ();
    tscw_word_decode u_decode (
        .slot(slot)
    );

    assign slotWord = connMem[{slotStream, slotChannel}];
    assign ctrlWord = connMem[{ctrlStream, ctrlChannel}];
    assign cmemRead = connMem[cmemSel_ff];
    assign slot.word = slotWord;
    assign slot.rate = rate_ff;

    // Connection memory has no reset: software loads every word before enabling outputs
    always_ff @(posedge clk_sys) begin
        if (regWrite && regAddr == ADDR_CMEM_DATA) begin
            connMem[cmemSel_ff] <= regWrData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rate_ff <= RATE_RESET;
            cmemSel_ff <= 11'h000;
            offsetSel_ff <= 4'h0;
        end else if (regWrite) begin
            if (regAddr == ADDR_CTRL) begin
                rate_ff <= (regWrData[1:0] == 2'h3) ? rate_ff : regWrData[1:0];
                offsetSel_ff <= regWrData[7:4];
            end else if (regAddr == ADDR_CMEM_SEL) begin
                cmemSel_ff <= regWrData[10:0];
            end
        end
    end

    // Latest measurement; half flag is high when the edge fell in clock-high phase
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            delay_ff <= DELAY_RESET;
            delayValid_ff <= 1'b0;
        end else if (evaluationDone) begin
            delay_ff <= measuredDelay;
            delayValid_ff <= 1'b1;
        end
    end

    // Writing the offset register with bit 15 set loads the mapped measurement
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            offsets_ff <= '0;
        end else if (regWrite && regAddr == ADDR_OFFSET) begin
            if (regWrData[15]) begin
                offsets_ff[offsetSel_ff*OFS_FIELD_W +: OFS_FIELD_W] <= {delay_ff[2:0], ~delay_ff[11]};
            end else begin
                offsets_ff[offsetSel_ff*OFS_FIELD_W +: OFS_FIELD_W] <= regWrData[3:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            streamOffset_ff <= 4'h0;
            halfCycleEnable_ff <= 1'b0;
        end else begin
            streamOffset_ff <= {1'b0, offsets_ff[offsetSel_ff*OFS_FIELD_W+OFS_VAL_POS +: 3]};
            halfCycleEnable_ff <= offsets_ff[offsetSel_ff*OFS_FIELD_W+OFS_HALF_POS];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_ff <= 16'h0000;
        end else if (regRead) begin
            if (regAddr == ADDR_CTRL) begin
                regRdData_ff <= {8'h00, offsetSel_ff, 2'h0, rate_ff};
            end else if (regAddr == ADDR_DELAY) begin
                regRdData_ff <= {3'h0, delayValid_ff, delay_ff};
            end else if (regAddr == ADDR_OFFSET) begin
                regRdData_ff <= {12'h000, offsets_ff[offsetSel_ff*OFS_FIELD_W +: OFS_FIELD_W]};
            end else if (regAddr == ADDR_CMEM_SEL) begin
                regRdData_ff <= {5'h00, cmemSel_ff};
            end else if (regAddr == ADDR_CMEM_DATA) begin
                regRdData_ff <= cmemRead;
            end else begin
                regRdData_ff <= 16'h0000;
            end
        end else begin
            regRdData_ff <= 16'h0000;
        end
    end

    // Read address is issued one slot ahead; the returned byte is chosen in the next slot
    logic msgPending_ff;
    logic [7:0] msgByte_ff;
    logic outEnPending_ff;
    logic lbPending_ff;
    logic [10:0] lbAddr_ff;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dataMemAddr_ff <= 11'h000;
            msgPending_ff <= 1'b0;
            msgByte_ff <= 8'h00;
            constDelay_ff <= 1'b0;
            outEnPending_ff <= 1'b0;
            lbPending_ff <= 1'b0;
            lbAddr_ff <= 11'h000;
        end else if (slotStrobe) begin
            dataMemAddr_ff <= {slot.srcStream, slot.srcChannel};
            msgPending_ff <= slot.messageSel;
            msgByte_ff <= slot.msgByte;
            constDelay_ff <= slot.constDelay;
            outEnPending_ff <= slot.outEnable;
            lbPending_ff <= slot.loopback;
            lbAddr_ff <= {slotStream, slotChannel};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            serialOutByte_ff <= 8'h00;
            serialOutEnable_ff <= 1'b0;
        end else if (slotStrobe) begin
            serialOutByte_ff <= msgPending_ff ? msgByte_ff : dataMemRdByte;
            // Enable travels with its byte so a floated slot never exposes the next one's data
            serialOutEnable_ff <= outEnPending_ff;
        end
    end

    // Loopback: the byte now on the output is written back into the input slot of its own stream/channel
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            loopbackWrite_ff <= 1'b0;
            loopbackAddr_ff <= 11'h000;
        end else begin
            loopbackWrite_ff <= slotStrobe && lbPending_ff;
            if (slotStrobe) begin
                loopbackAddr_ff <= lbAddr_ff;
            end
        end
    end

    // Front end walks ctrlStream 0..15 for the channel after the current one
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            controlSerialOut_ff <= 1'b0;
        end else if (ctrlStrobe) begin
            controlSerialOut_ff <= ctrlWord[CTRLOUT_BIT];
        end
    end
endmodule

// ### tb/tscw_switch_properties.sv
// Assertions on the connection-word switch ports.
// Assumes slot and control strobes come several cycles apart.
`timescale 1ns/10ps
module tscw_switch_properties
    import tscw_pkg::*;
(
    // Clock, reset and register port
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdData_ff,
    // Slot path
    input wire logic slotStrobe,
    input wire logic ctrlStrobe,
    input wire logic [10:0] dataMemAddr_ff,
    input wire logic constDelay_ff,
    input wire logic loopbackWrite_ff,
    input wire logic controlSerialOut_ff,
    input wire logic [3:0] streamOffset_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [1:0] rate_ff;
    // Rate code 3 is refused by the core, so the shadow skips it too
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rate_ff <= RATE_RESET;
        end else if (regWrite && regAddr == ADDR_CTRL && regWrData[1:0] != 2'h3) begin
            rate_ff <= regWrData[1:0];
        end
    end
    property p_rd_idle; regRdData_ff != 16'h0 |-> $past(regRead); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read answer");
    property p_unmapped; regRead && regAddr > ADDR_STATUS |=> regRdData_ff == 16'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_addr_hold; $changed(dataMemAddr_ff) |-> $past(slotStrobe) || $past(slotStrobe, 2); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("read address moved without a slot");
    property p_rate_mask; slotStrobe && rate_ff == RATE_LOW |-> ##[1:2] dataMemAddr_ff[6:5] == 2'h0; endproperty
    a_rate_mask: assert property (p_rate_mask) else $error("unused channel bits reached the address");
    property p_const_hold; $changed(constDelay_ff) |-> $past(slotStrobe) || $past(slotStrobe, 2); endproperty
    a_const_hold: assert property (p_const_hold) else $error("delay mode moved without a slot");
    property p_ctrl_hold; $changed(controlSerialOut_ff) |-> $past(ctrlStrobe) || $past(ctrlStrobe, 2); endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control bit moved without a strobe");
    property p_lb_pulse; loopbackWrite_ff |-> $past(slotStrobe) ##1 !loopbackWrite_ff; endproperty
    a_lb_pulse: assert property (p_lb_pulse) else $error("loopback write not a slot pulse");
    property p_ofs_top; streamOffset_ff[3] == 1'b0; endproperty
    a_ofs_top: assert property (p_ofs_top) else $error("offset field wider than three bits");
endmodule
bind tscw_switch tscw_switch_properties i_props(.clk_sys, .rst_b, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData_ff, .slotStrobe, .ctrlStrobe, .dataMemAddr_ff, .constDelay_ff, .loopbackWrite_ff,
    .controlSerialOut_ff, .streamOffset_ff);

// ### tb/tscw_front_end.sv
// Serial front end and data memory model facing the switch core.
// Assumes run stays low through reset; one slot every fourth cycle.
`timescale 1ns/10ps
module tscw_front_end #(
    parameter int CH = 4
)(
    // Clock and pacing
    input wire logic clk_sys,
    input wire logic run,
    // Switch side
    input wire logic [10:0] dataMemAddr_ff,
    output logic [3:0] slotStream,
    output logic [6:0] slotChannel,
    output logic slotStrobe,
    output logic [3:0] ctrlStream,
    output logic [6:0] ctrlChannel,
    output logic ctrlStrobe,
    output logic [7:0] dataMemRdByte
);
    logic [1:0] ph_ff;
    logic [3:0] st_ff;
    logic [6:0] ch_ff;
    initial {slotStream, slotChannel, slotStrobe, ctrlStream, ctrlChannel, ctrlStrobe, dataMemRdByte} = '0;
    always @(posedge clk_sys) begin
        // Byte depends on every address bit so a wrong address shows
        dataMemRdByte <= dataMemAddr_ff[7:0] ^ {2{dataMemAddr_ff[10:7]}};
        ph_ff <= run ? ph_ff + 2'h1 : 2'h0;
        slotStrobe <= run && ph_ff == 2'h0;
        ctrlStrobe <= run && ph_ff == 2'h0;
        if (!run) begin
            st_ff <= 4'h0;
            ch_ff <= 7'h0;
        end else if (ph_ff == 2'h0) begin
            slotStream <= st_ff;
            slotChannel <= ch_ff;
            ctrlStream <= st_ff;
            ctrlChannel <= 7'((ch_ff + 1) % CH);
            st_ff <= st_ff + 4'h1;
            if (st_ff == 4'hf) begin
                ch_ff <= 7'((ch_ff + 1) % CH);
            end
        end
    end
endmodule

// ### tb/tb.sv
// Self-checking bench for the connection-word switch core.
// Assumes the front-end model paces slots and the register port answers next cycle.
`timescale 1ns/10ps
module tb
    import tscw_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic run = 1'b0;
    logic [7:0] regAddr = 8'h0;
    logic [15:0] regWrData = 16'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [11:0] measuredDelay = 12'h0;
    logic evaluationDone = 1'b0;
    logic [15:0] regRdData_ff, lastW_ff;
    logic [3:0] slotStream, ctrlStream, streamOffset_ff;
    logic [6:0] slotChannel, ctrlChannel;
    logic [10:0] dataMemAddr_ff, loopbackAddr_ff, ctrlIdx_ff;
    logic [7:0] dataMemRdByte, serialOutByte_ff;
    logic slotStrobe, ctrlStrobe, serialOutEnable_ff, constDelay_ff, loopbackWrite_ff;
    logic controlSerialOut_ff, halfCycleEnable_ff;
    logic rdSeen_ff = 1'b0;
    logic ctrlSeen_ff = 1'b0;
    logic slotSeen_ff = 1'b0;
    logic [12:0] lbExp_ff = 13'h0000;
    logic [10:0] lastIdx_ff = 11'h000;
    logic [15:0] cw [2048];
    logic [1:0] rate = 2'h0;
    logic [15:0] rQ[$];
    logic [8:0] sQ[$];
    int fail_count = 0, compares = 0, cyc = 0, seed = 13755;
    always #12.5 clk_sys = ~clk_sys;
    tscw_switch i_dut(.clk_sys, .rst_b, .regAddr, .regWrData, .regWrite, .regRead, .regRdData_ff, .slotStream,
        .slotChannel, .slotStrobe, .ctrlStream, .ctrlChannel, .ctrlStrobe, .measuredDelay, .evaluationDone,
        .dataMemRdByte, .dataMemAddr_ff, .serialOutByte_ff, .serialOutEnable_ff, .constDelay_ff,
        .loopbackWrite_ff, .loopbackAddr_ff, .controlSerialOut_ff, .streamOffset_ff, .halfCycleEnable_ff);
    tscw_front_end i_fe(.clk_sys, .run, .dataMemAddr_ff, .slotStream, .slotChannel, .slotStrobe,
        .ctrlStream, .ctrlChannel, .ctrlStrobe, .dataMemRdByte);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("Compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        regRead <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        regWrite <= 1'b0;
        rQ.push_back(e);
    endtask
    task automatic idle;
        @(posedge clk_sys);
        regRead <= 1'b0;
        regWrite <= 1'b0;
    endtask
    function automatic logic [8:0] expOut(input logic [15:0] w);
        logic [10:0] a;
        a = {w[10:7], w[6:0] & (rate == RATE_LOW ? 7'h1f : rate == RATE_MID ? 7'h3f : 7'h7f)};
        return {w[11], w[13] ? w[7:0] : a[7:0] ^ {2{a[10:7]}}};
    endfunction
    always @(posedge clk_sys) begin
        logic [8:0] e;
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
        rdSeen_ff <= regRead;
        if (rdSeen_ff) chk(regRdData_ff, rQ.pop_front());
        slotSeen_ff <= slotStrobe;
        if (slotSeen_ff) chk(constDelay_ff, lastW_ff[14]);
        if (slotSeen_ff && lbExp_ff[12]) chk({loopbackWrite_ff, loopbackAddr_ff}, lbExp_ff[11:0]);
        if (!run) sQ.delete();
        ctrlSeen_ff <= run && (ctrlSeen_ff || ctrlStrobe);
        if (slotStrobe) begin
            // Loopback of the previous slot of this run is written with that slot's byte
            lbExp_ff <= {sQ.size() > 0, lastW_ff[15], lastIdx_ff};
            // Output of a slot stands from just after the next strobe until the one after
            if (sQ.size() >= 2) begin
                e = sQ.pop_front();
                chk(serialOutEnable_ff, e[8]);
                chk(serialOutByte_ff, e[7:0]);
            end
            sQ.push_back(expOut(cw[{slotStream, slotChannel}]));
            lastW_ff <= cw[{slotStream, slotChannel}];
            lastIdx_ff <= {slotStream, slotChannel};
        end
        if (ctrlStrobe) begin
            if (ctrlSeen_ff) chk(controlSerialOut_ff, cw[ctrlIdx_ff][12]);
            ctrlIdx_ff <= {ctrlStream, ctrlChannel};
        end
    end
    initial begin
        logic [15:0] w;
        logic [11:0] d;
        logic [10:0] idx;
        int j;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        // Each pass maps onto its own stream; stream 0 stays at zero offset for its loopback channel
        for (int i = 0; i < 11; i++) begin
            j = i % 10;
            d = {~j[0], 8'($random(seed)), 3'(j >> 1)};
            @(posedge clk_sys);
            measuredDelay <= d;
            evaluationDone <= 1'b1;
            @(posedge clk_sys);
            evaluationDone <= 1'b0;
            wr(ADDR_CTRL, {8'h00, 4'(i), 4'h0});
            rd(ADDR_DELAY, {4'h1, d});
            wr(ADDR_OFFSET, 16'h8000);
            rd(ADDR_OFFSET, {12'h0, 3'(j >> 1), j[0]});
            idle();
            #1;
            chk(streamOffset_ff, {1'b0, 3'(j >> 1)});
            chk(halfCycleEnable_ff, j[0]);
        end
        $display("Test offset done");
        wr(ADDR_CTRL, 16'h0003);
        rd(ADDR_CTRL, 16'h0000);
        rd(8'h3c, 16'h0000);
        for (int r = 0; r < 3; r++) begin
            wr(ADDR_CTRL, 16'(r));
            rate = 2'(r);
            for (int k = 0; k < 64; k++) begin
                w = 16'($random(seed));
                w[15] = (k == 0);
                idx = {4'(k % 16), 7'(k / 16)};
                cw[idx] = w;
                wr(ADDR_CMEM_SEL, {5'h0, idx});
                wr(ADDR_CMEM_DATA, w);
                rd(ADDR_CMEM_DATA, w);
            end
            idle();
            run <= 1'b1;
            repeat (768) @(posedge clk_sys);
            run <= 1'b0;
            $display("Test rate %0d done", r);
        end
        repeat (4) @(posedge clk_sys);
        complete_run();
    end
endmodule
